//--- hw/lts_pkg.sv
package lts_pkg;

    // ------------------------------------------------------------
    // Register offsets on the host port
    // ------------------------------------------------------------
    localparam logic [4:0] MC_OFS = 5'h06;
    localparam logic [4:0] GMR_OFS = 5'h07;
    localparam logic [4:0] ETC_OFS = 5'h10;
    localparam logic [4:0] VINS_OFS = 5'h11;
    localparam logic [4:0] LVST_OFS = 5'h12;
    localparam logic [4:0] RINV_OFS = 5'h13;
    localparam logic [4:0] TINV_OFS = 5'h14;
    localparam logic [4:0] CRC_OFS = 5'h15;
    localparam logic [4:0] GLOBAL_IRQ_STATUS_CTRL_OFS = 5'h1E;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MC_PLL_SRC_BIT = 6;
    localparam int GMR_HITLESS_BIT = 0;
    localparam int GMR_JA_LSB = 1;
    localparam int ETC_EN_BIT = 0;
    localparam int ETC_SEL_LSB = 5;
    localparam int GLOBAL_IRQ_STATUS_CTRL_CWE_BIT = 0;
    localparam int CRC_AUX_LSB = 0;
    localparam int CRC_RATE_BIT = 4;
    localparam int CRC_PSEL_LSB = 5;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MC_MASK = 8'h7F;
    localparam logic [7:0] GMR_MASK = 8'h07;
    localparam logic [7:0] ETC_MASK = 8'hE1;
    localparam logic [7:0] GLOBAL_IRQ_STATUS_CTRL_MASK = 8'h03;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int VIOL_WINDOW_CYC = 3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } lts_host_req_t;

    typedef struct packed {
        logic [7:0] bipolar_violation;
        logic [7:0] code_violation;
        logic [7:0] excess_zero;
        logic [7:0] signal_loss;
    } lts_line_evt_t;

    typedef struct packed {
        logic [7:0] mc;
        logic [7:0] gmr;
        logic [7:0] etc;
        logic [7:0] vins;
        logic [7:0] vins_prev;
        logic [7:0] rinv;
        logic [7:0] tinv;
        logic [7:0] crc;
        logic [7:0] global_irq_status_ctrl;
        logic [7:0] rdata;
        logic clock_edge_select_pin_s1;
        logic clock_edge_select_pin_s2;
        logic oe_s1;
        logic oe_s2;
        logic [7:0] ins_pulse;
        logic [7:0] tester_onehot;
        logic [7:0] rx_fall;
        logic imp_off;
        logic pll_recov;
    } lts_state_t;

    typedef struct packed {
        logic status;
        logic [1:0] hold;
    } lts_latch_state_t;

endpackage

//--- hw/lts_viol_latch.sv
`timescale 1ns/100ps

// One channel's latched line-violation status bit with its hold-off window
module lts_viol_latch
    import lts_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Event and clear
    input wire logic event_in,
    input wire logic clear_in,
    // Status
    output logic status
);

    lts_latch_state_t cur;
    lts_latch_state_t next_cur;
    logic take;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // A read during the hold-off does not reopen the window
    always_comb
    begin
        next_cur = cur;
        take = event_in && (cur.hold == 2'h0);
        if (cur.hold != 2'h0)
        begin
            next_cur.hold = cur.hold - 2'h1;
        end
        if (take)
        begin
            next_cur.hold = 2'(VIOL_WINDOW_CYC - 1);
        end
        // Set wins over a clear in the same cycle
        if (take)
        begin
            next_cur.status = 1'b1;
        end
        else if (clear_in)
        begin
            next_cur.status = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign status = cur.status;

endmodule

//--- hw/lts_regs.sv
`timescale 1ns/100ps

module lts_regs
    import lts_pkg::*;
#(
    parameter int CHANNELS = 8
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Host port, already on sys_clk
    input wire lts_host_req_t host_req,
    output logic [7:0] host_rdata,
    // Line events from the channel decoders
    input wire lts_line_evt_t line_evt,
    // Line mode straps
    input wire logic rail_mode_dual,
    input wire logic line_code_hdb3,
    input wire logic excess_zero_detect_enable,
    input wire logic code_violation_detect_off,
    // Device pins, asynchronous
    input wire logic clock_edge_select_pin,
    input wire logic output_enable_pin,
    // Line unit controls
    output logic [1:0] jitter_bandwidth_code,
    output logic impedance_match_off,
    output logic tester_enable,
    output logic [2:0] tester_channel_select,
    output logic [7:0] tester_channel_onehot,
    output logic [7:0] violation_insert_pulse,
    output logic [7:0] line_violation_status,
    // Clock edge controls
    output logic [7:0] rx_data_on_falling,
    output logic [7:0] tx_data_on_rising,
    // Clock routing
    output logic pll_use_recovered,
    output logic [2:0] pll_reference_select,
    output logic line_rate_clock_select,
    output logic [3:0] aux_clock_select
);

    lts_state_t cur;
    lts_state_t next_cur;
    logic [7:0] viol_event;
    logic [7:0] viol_clear;
    logic [7:0] lv_status;
    logic wr_hit_lvst;
    logic rd_hit_lvst;
    logic clear_by_write_enable;

    // ------------------------------------------------------------
    // Violation qualification
    // ------------------------------------------------------------
    // Code violations and excess zeros only matter in single-rail
    always_comb
    begin
        viol_event = line_evt.bipolar_violation;
        if (!rail_mode_dual)
        begin
            if (line_code_hdb3 && !code_violation_detect_off)
            begin
                viol_event = viol_event | line_evt.code_violation;
            end
            if (excess_zero_detect_enable)
            begin
                viol_event = viol_event | line_evt.excess_zero;
            end
        end
    end

    // ------------------------------------------------------------
    // Status clear decode
    // ------------------------------------------------------------
    // Clear-on-write takes only the bits written as one
    assign clear_by_write_enable = cur.global_irq_status_ctrl[GLOBAL_IRQ_STATUS_CTRL_CWE_BIT];
    assign wr_hit_lvst = host_req.wr && (host_req.addr == LVST_OFS);
    assign rd_hit_lvst = host_req.rd && (host_req.addr == LVST_OFS);

    always_comb
    begin
        viol_clear = 8'h00;
        if (clear_by_write_enable && wr_hit_lvst)
        begin
            viol_clear = host_req.wdata;
        end
        else if (!clear_by_write_enable && rd_hit_lvst)
        begin
            viol_clear = 8'hFF;
        end
    end

    // ------------------------------------------------------------
    // Per-channel status latches
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_lat
            lts_viol_latch u_lat
            (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .event_in(viol_event[ch]),
                .clear_in(viol_clear[ch]),
                .status(lv_status[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;

        // Pins pass two flops before use
        next_cur.clock_edge_select_pin_s1 = clock_edge_select_pin;
        next_cur.clock_edge_select_pin_s2 = cur.clock_edge_select_pin_s1;
        next_cur.oe_s1 = output_enable_pin;
        next_cur.oe_s2 = cur.oe_s1;

        // Register writes; reserved bits stay zero
        if (host_req.wr)
        begin
            case (host_req.addr)
                MC_OFS:
                begin
                    next_cur.mc = host_req.wdata & MC_MASK;
                end
                GMR_OFS:
                begin
                    next_cur.gmr = host_req.wdata & GMR_MASK;
                end
                ETC_OFS:
                begin
                    next_cur.etc = host_req.wdata & ETC_MASK;
                end
                VINS_OFS:
                begin
                    next_cur.vins = host_req.wdata;
                end
                RINV_OFS:
                begin
                    next_cur.rinv = host_req.wdata;
                end
                TINV_OFS:
                begin
                    next_cur.tinv = host_req.wdata;
                end
                CRC_OFS:
                begin
                    next_cur.crc = host_req.wdata;
                end
                GLOBAL_IRQ_STATUS_CTRL_OFS:
                begin
                    next_cur.global_irq_status_ctrl = host_req.wdata & GLOBAL_IRQ_STATUS_CTRL_MASK;
                end
                default:
                begin
                    next_cur.mc = cur.mc;
                end
            endcase
        end

        // Register reads; unmapped addresses return zero
        if (host_req.rd)
        begin
            case (host_req.addr)
                MC_OFS: next_cur.rdata = cur.mc;
                GMR_OFS: next_cur.rdata = cur.gmr;
                ETC_OFS: next_cur.rdata = cur.etc;
                VINS_OFS: next_cur.rdata = cur.vins;
                LVST_OFS: next_cur.rdata = lv_status;
                RINV_OFS: next_cur.rdata = cur.rinv;
                TINV_OFS: next_cur.rdata = cur.tinv;
                CRC_OFS: next_cur.rdata = cur.crc;
                GLOBAL_IRQ_STATUS_CTRL_OFS: next_cur.rdata = cur.global_irq_status_ctrl;
                default: next_cur.rdata = 8'h00;
            endcase
        end

        // One violation per 0-to-1 step of an insert bit
        next_cur.vins_prev = cur.vins;
        next_cur.ins_pulse = cur.vins & ~cur.vins_prev;

        // Only one channel at a time, and none while disabled
        next_cur.tester_onehot = 8'h00;
        if (cur.etc[ETC_EN_BIT])
        begin
            next_cur.tester_onehot[cur.etc[ETC_SEL_LSB +: 3]] = 1'b1;
        end

        // Edge pin overrides the per-channel invert bits
        next_cur.rx_fall = cur.rinv | {8{cur.clock_edge_select_pin_s2}};

        // Matching off only while the enable pin is low
        next_cur.imp_off = cur.gmr[GMR_HITLESS_BIT] && !cur.oe_s2;

        // Loss on the chosen channel reverts the PLL to master clock
        next_cur.pll_recov = cur.mc[MC_PLL_SRC_BIT]
            && !line_evt.signal_loss[cur.crc[CRC_PSEL_LSB +: 3]];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All straight from flops, so no glitches reach the line units
    assign host_rdata = cur.rdata;
    assign jitter_bandwidth_code = cur.gmr[GMR_JA_LSB +: 2];
    assign impedance_match_off = cur.imp_off;
    assign tester_enable = cur.etc[ETC_EN_BIT];
    assign tester_channel_select = cur.etc[ETC_SEL_LSB +: 3];
    assign tester_channel_onehot = cur.tester_onehot;
    assign violation_insert_pulse = cur.ins_pulse;
    assign line_violation_status = lv_status;
    assign rx_data_on_falling = cur.rx_fall;
    assign tx_data_on_rising = cur.tinv;
    assign pll_use_recovered = cur.pll_recov;
    assign pll_reference_select = cur.crc[CRC_PSEL_LSB +: 3];
    assign line_rate_clock_select = cur.crc[CRC_RATE_BIT];
    assign aux_clock_select = cur.crc[CRC_AUX_LSB +: 4];

endmodule

//--- sim/lts_chk_asserts.sv
`timescale 1ns/100ps

// ----------------------------------------
// Port checker for the register bank
// ----------------------------------------
module lts_chk
    import lts_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Host and line side
    input wire lts_host_req_t host_req,
    input wire lts_line_evt_t line_evt,
    input wire logic rail_mode_dual,
    input wire logic clock_edge_select_pin,
    // Watched outputs
    input wire logic [1:0] jitter_bandwidth_code,
    input wire logic tester_enable,
    input wire logic [2:0] tester_channel_select,
    input wire logic [7:0] tester_channel_onehot,
    input wire logic [7:0] violation_insert_pulse,
    input wire logic [7:0] line_violation_status,
    input wire logic [7:0] rx_data_on_falling,
    input wire logic pll_use_recovered,
    input wire logic [2:0] pll_reference_select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] any_evt;
    logic [7:0] lvs;
    // Any event kind; gating by mode is checked in the bench
    assign any_evt = line_evt.bipolar_violation | line_evt.code_violation | line_evt.excess_zero;
    assign lvs = line_violation_status;

    jitter_load_a: assert property (host_req.wr && host_req.addr == GMR_OFS
        |=> jitter_bandwidth_code == $past(host_req.wdata[2:1])) else $error("jitter code");
    onehot_track_a: assert property (tester_channel_onehot == ($past(tester_enable) ?
        8'h01 << $past(tester_channel_select) : 8'h00)) else $error("tester channel");
    insert_single_a: assert property (
        (violation_insert_pulse & $past(violation_insert_pulse)) == 8'h00) else $error("insert");
    status_cause_a: assert property (
        (lvs & ~$past(lvs) & ~$past(any_evt)) == 8'h00) else $error("status cause");
    window_hold_a: assert property ($rose(lvs[1]) |=> !$rose(lvs[1]) [*2])
        else $error("window");
    dual_rail_a: assert property ($past(rail_mode_dual) |->
        (lvs & ~$past(lvs) & ~$past(line_evt.bipolar_violation)) == 8'h00) else $error("dual");
    edge_pin_a: assert property (clock_edge_select_pin [*4] |=>
        rx_data_on_falling == 8'hFF) else $error("edge pin");
    loss_fall_a: assert property (line_evt.signal_loss[pll_reference_select] |=>
        !pll_use_recovered) else $error("pll loss");
    reset_zero_a: assert property (disable iff (1'b0) !reset_n |-> lvs == 8'h00 &&
        tester_channel_onehot == 8'h00 && !pll_use_recovered) else $error("reset");

    cover property (clock_edge_select_pin [*4]);
    cover property ($rose(lvs[1]));
    cover property (line_evt.signal_loss[pll_reference_select]);
endmodule

bind lts_regs lts_chk lts_chk_inst (.sys_clk, .reset_n, .host_req, .line_evt,
    .rail_mode_dual, .clock_edge_select_pin, .jitter_bandwidth_code, .tester_enable,
    .tester_channel_select, .tester_channel_onehot, .violation_insert_pulse,
    .line_violation_status, .rx_data_on_falling, .pll_use_recovered, .pll_reference_select);

//--- sim/lts_line_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Line decoder model on the far side
// ----------------------------------------
module lts_line_model
    import lts_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bench events and transmit side
    input wire lts_line_evt_t inj,
    input wire logic [7:0] violation_insert_pulse,
    // Decoded events
    output lts_line_evt_t line_evt
);
    logic [7:0] loop_q;
    // Looped line: an inserted violation is seen one cycle later
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            loop_q <= 8'h00;
        else
            loop_q <= violation_insert_pulse;
    end
    // Bench events merge with looped ones
    always_comb
    begin
        line_evt = inj;
        line_evt.bipolar_violation = inj.bipolar_violation | loop_q;
    end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps

// ----------------------------------------
// Bench for the register bank
// ----------------------------------------
module tb_top;
    import lts_pkg::*;
    logic sys_clk, reset_n;
    lts_host_req_t host_req;
    lts_line_evt_t inj, line_evt;
    logic rail_mode_dual, line_code_hdb3, excess_zero_detect_enable, code_violation_detect_off;
    logic clock_edge_select_pin, output_enable_pin, impedance_match_off, tester_enable;
    logic pll_use_recovered, line_rate_clock_select;
    logic [1:0] jitter_bandwidth_code;
    logic [2:0] tester_channel_select, pll_reference_select;
    logic [3:0] aux_clock_select;
    logic [7:0] host_rdata, tester_channel_onehot, violation_insert_pulse, line_violation_status;
    logic [7:0] rx_data_on_falling, tx_data_on_rising, v;
    int err_total, checks, seed, ins_cnt, e;
    int m[32];
    int ra[4] = '{16, 19, 20, 21};

    lts_regs lts_regs_inst (.sys_clk, .reset_n, .host_req, .host_rdata, .line_evt,
        .rail_mode_dual, .line_code_hdb3, .excess_zero_detect_enable,
        .code_violation_detect_off, .clock_edge_select_pin, .output_enable_pin,
        .jitter_bandwidth_code, .impedance_match_off, .tester_enable, .tester_channel_select,
        .tester_channel_onehot, .violation_insert_pulse, .line_violation_status,
        .rx_data_on_falling, .tx_data_on_rising, .pll_use_recovered, .pll_reference_select,
        .line_rate_clock_select, .aux_clock_select);
    lts_line_model lts_line_model_inst (.sys_clk, .reset_n, .inj, .violation_insert_pulse,
        .line_evt);

    // 40 MHz clock
    initial
    begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Counted on the falling edge so the pulse has settled
    always @(negedge sys_clk) ins_cnt += $countones(violation_insert_pulse);

    task chk(input string n, input logic [7:0] s, input logic [7:0] x);
        checks++;
        if (s !== x)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk) host_req <= '{1'b0, 1'b1, a, d};
        @(posedge sys_clk) host_req <= '0;
        m[a] = d;
    endtask
    task rd(input logic [4:0] a);
        @(posedge sys_clk) host_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge sys_clk) host_req <= '0;
        #1 v = host_rdata;
    endtask
    // Reserved bits read back as zero, so the model masks them
    task rm(input logic [4:0] a);
        rd(a);
        chk("reg", v, 8'(m[a]) & (a == 16 ? 8'hE1 : a == 6 ? 8'h7F : a == 7 ? 8'h07 :
            a == 30 ? 8'h03 : 8'hFF));
    endtask
    task close_out;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard well past the expected run length
    initial
    begin
        #1000000;
        err_total++;
        close_out();
    end

    // Main sequence
    initial
    begin
        reset_n = 0;
        host_req = '0;
        inj = '0;
        {rail_mode_dual, line_code_hdb3, excess_zero_detect_enable} = 3'h0;
        {code_violation_detect_off, clock_edge_select_pin, output_enable_pin} = 3'h0;
        seed = 50171;
        m = '{default: 0};
        cyc(4);
        @(posedge sys_clk) reset_n <= 1;
        for (int a = 0; a < 32; a++) rm(5'(a));
        repeat (8)
        begin
            foreach (ra[i]) wr(5'(ra[i]), 8'($random(seed)));
            cyc(2);
            chk("en", tester_enable, m[16][0]);
            chk("sel", tester_channel_select, m[16][7:5]);
            chk("hot", tester_channel_onehot, m[16][0] ? 8'h01 << m[16][7:5] : 8'h00);
            chk("rxf", rx_data_on_falling, m[19]);
            chk("txr", tx_data_on_rising, m[20]);
            chk("psel", pll_reference_select, m[21][7:5]);
            chk("rate", line_rate_clock_select, m[21][4]);
            chk("aux", aux_clock_select, m[21][3:0]);
            foreach (ra[i]) rm(5'(ra[i]));
        end
        for (int k = 0; k < 8; k++)
        begin
            wr(7, 8'(k));
            cyc(2);
            chk("jit", jitter_bandwidth_code, k[2:1]);
            chk("imp", impedance_match_off, k[0]);
        end
        @(posedge sys_clk) output_enable_pin <= 1;
        cyc(5);
        chk("imp", impedance_match_off, 0);
        @(posedge sys_clk) clock_edge_select_pin <= 1;
        cyc(5);
        chk("rxf", rx_data_on_falling, 8'hFF);
        @(posedge sys_clk) clock_edge_select_pin <= 0;
        wr(17, 0);
        cyc(4);
        ins_cnt = 0;
        wr(17, 1);
        cyc(4);
        wr(17, 1);
        cyc(4);
        wr(17, 0);
        wr(17, 8'h81);
        cyc(4);
        chk("ins", 8'(ins_cnt), 3);
        rd(18);
        chk("lvs", v, 8'h81);
        rd(18);
        chk("lvs", v, 0);
        @(posedge sys_clk) inj.bipolar_violation <= 8'h02;
        @(posedge sys_clk) host_req <= '{1'b1, 1'b0, LVST_OFS, 8'h00};
        inj <= '0;
        @(posedge sys_clk) host_req <= '0;
        inj.bipolar_violation <= 8'h02;
        @(posedge sys_clk) inj <= '0;
        cyc(3);
        chk("lvs", host_rdata, 8'h02);
        rd(18);
        chk("lvs", v, 0);
        for (int k = 0; k < 16; k++)
        begin
            @(posedge sys_clk) {rail_mode_dual, line_code_hdb3, excess_zero_detect_enable,
                code_violation_detect_off} <= 4'(k);
            cyc(2);
            @(posedge sys_clk) inj <= '{8'h00, 8'h04, 8'h40, 8'h00};
            @(posedge sys_clk) inj <= '0;
            cyc(3);
            rd(18);
            e = k[3] ? 0 : ((k[2] && !k[0]) ? 8'h04 : 0) | (k[1] ? 8'h40 : 0);
            chk("mode", v, 8'(e));
        end
        @(posedge sys_clk) rail_mode_dual <= 0;
        wr(30, 1);
        @(posedge sys_clk) inj.bipolar_violation <= 8'h20;
        @(posedge sys_clk) inj <= '0;
        cyc(3);
        rd(18);
        chk("cwe", v, 8'h20);
        wr(18, 0);
        rd(18);
        chk("cwe", v, 8'h20);
        wr(18, 8'h20);
        rd(18);
        chk("cwe", v, 0);
        rm(30);
        wr(6, 8'h40);
        wr(21, 8'h60);
        cyc(2);
        chk("pll", pll_use_recovered, 1);
        @(posedge sys_clk) inj.signal_loss <= 8'h08;
        cyc(2);
        chk("pll", pll_use_recovered, 0);
        @(posedge sys_clk) inj.signal_loss <= 8'h10;
        cyc(2);
        chk("pll", pll_use_recovered, 1);
        wr(6, 0);
        cyc(2);
        chk("pll", pll_use_recovered, 0);
        close_out();
    end
endmodule
